//--- common/ctl_list_consts.svh
`ifndef CTL_LIST_CONSTS_SVH
`define CTL_LIST_CONSTS_SVH

// register byte offsets
`define OFS_HEAD_DESC 8'h20
`define OFS_CURRENT_DESC 8'h24
`define OFS_OPERATING_CONTROL 8'h40
`define OFS_COMMAND_STATUS 8'h44

// pointer field sits in bits 31..4, bits 3..0 reserved
`define PTR_FIELD_LSB 4
`define PTR_FIELD_W 28
`define PTR_RSVD_VALUE 4'h0

// control bits
`define CTRL_LIST_ENABLE_BIT 0
`define STAT_LIST_FILLED_BIT 1

// reset values
`define RESET_PTR 28'h0000000
`define RESET_ENABLE 1'b0
`define RESET_FILLED 1'b0

// bus answers
`define HRESP_OKAY 1'b0
`define HTRANS_NONSEQ_BIT 1

`endif

//--- common/ctl_list_pkg.sv
package ctl_list_pkg;

    // one captured address phase of the register bus
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } bus_req_t;

    // report from the list walker that a descriptor has been served
    typedef struct packed {
        logic done;
        logic [27:0] next_ptr;
    } advance_t;

endpackage : ctl_list_pkg

//--- rtl/ahb_addr_capture.sv
`timescale 1ns/1ps
`include "ctl_list_consts.svh"

module ahb_addr_capture (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // address phase
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    // held request for the data phase
    output ctl_list_pkg::bus_req_t req
);

    wire logic accept;

    assign accept = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req <= '0;
        end else if (hready) begin
            req.valid <= accept;
            req.write <= hwrite;
            req.addr <= haddr;
        end
    end

endmodule : ahb_addr_capture

//--- rtl/ptr_register.sv
`timescale 1ns/1ps
`include "ctl_list_consts.svh"

module ptr_register #(
    parameter int W = `PTR_FIELD_W
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // loads, first one wins
    input wire logic load_hi,
    input wire logic [W-1:0] data_hi,
    input wire logic load_lo,
    input wire logic [W-1:0] data_lo,
    // held pointer
    output logic [W-1:0] ptr
);

    wire logic [W-1:0] next_ptr;

    assign next_ptr = load_hi ? data_hi : (load_lo ? data_lo : ptr);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ptr <= W'(`RESET_PTR);
        end else begin
            ptr <= next_ptr;
        end
    end

endmodule : ptr_register

//--- rtl/control_list_current_pointer.sv
// Notes on behaviour
// - current descriptor register is readable at offset 24h
// - pointer in bits 31..4, bits 3..0 reserved and read zero
// - after a descriptor is served, pointer moves to the next one
// - new frame does not touch the pointer; walking resumes there
// - at list end: if filled flag set, copy head, clear the flag
// - while enabled, software only reads the live pointer value
// - pointer resets to zero, meaning end of list
// - head pointer loads from the communication area at init
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "ctl_list_consts.svh"

module control_list_current_pointer (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // list walker
    input wire ctl_list_pkg::advance_t advance,
    input wire logic frame_start,
    // controller initialisation
    input wire logic init_load,
    input wire logic [27:0] hca_head_ptr,
    // state seen by the walker
    output logic [27:0] current_ptr,
    output logic list_end,
    output logic list_enable,
    output logic list_filled
);

    ctl_list_pkg::bus_req_t req;
    logic [27:0] head_ptr;
    logic [27:0] cur_q;
    logic enable_q;
    logic filled_q;

    wire logic accept;
    wire logic wr_phase;
    wire logic wr_head;
    wire logic wr_cur;
    wire logic wr_ctrl;
    wire logic wr_stat;
    wire logic at_end;
    wire logic reload;
    wire logic step;
    wire logic cur_load_hi;
    wire logic [27:0] cur_data_hi;
    wire logic set_filled;
    wire logic next_filled;
    wire logic [31:0] cur_word;
    wire logic [31:0] head_word;
    wire logic [31:0] next_rdata;

    ahb_addr_capture u_capture (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .req(req)
    );

    // write decode, done in the data phase when hwdata stands
    assign accept = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
    assign wr_phase = req.valid & req.write;
    assign wr_head = wr_phase & (req.addr == `OFS_HEAD_DESC);
    // write gate
    // current pointer writes while enabled are dropped so the walker never races software
    assign wr_cur = wr_phase & (req.addr == `OFS_CURRENT_DESC) & ~enable_q;
    assign wr_ctrl = wr_phase & (req.addr == `OFS_OPERATING_CONTROL);
    assign wr_stat = wr_phase & (req.addr == `OFS_COMMAND_STATUS);

    assign at_end = (cur_q == 28'h0000000);
    assign reload = enable_q & at_end & filled_q;
    assign step = enable_q & advance.done & ~reload;
    assign cur_load_hi = wr_cur | reload;
    assign cur_data_hi = wr_cur ?
        hwdata[31:`PTR_FIELD_LSB] : head_ptr;

    // frame start
    // frame_start feeds no load, so the walk resumes where it stopped
    ptr_register #(
        .W(`PTR_FIELD_W)
    ) u_current (
        .hclk(hclk),
        .hresetn(hresetn),
        .load_hi(cur_load_hi),
        .data_hi(cur_data_hi),
        .load_lo(step),
        .data_lo(advance.next_ptr),
        .ptr(cur_q)
    );

    ptr_register #(
        .W(`PTR_FIELD_W)
    ) u_head (
        .hclk(hclk),
        .hresetn(hresetn),
        .load_hi(init_load),
        .data_hi(hca_head_ptr),
        .load_lo(wr_head),
        .data_lo(hwdata[31:`PTR_FIELD_LSB]),
        .ptr(head_ptr)
    );

    // flag clear on reload
    // a software set in the same cycle wins over the hardware clear
    assign set_filled = wr_stat & hwdata[`STAT_LIST_FILLED_BIT];
    assign next_filled = set_filled | (filled_q & ~reload);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_q <= `RESET_ENABLE;
            filled_q <= `RESET_FILLED;
        end else begin
            if (wr_ctrl) begin
                enable_q <= hwdata[`CTRL_LIST_ENABLE_BIT];
            end
            filled_q <= next_filled;
        end
    end

    assign cur_word = {cur_q, `PTR_RSVD_VALUE};
    assign head_word = {head_ptr, `PTR_RSVD_VALUE};

    // live value read
    // sampled at the address phase; unmapped offsets read zero
    assign next_rdata =
        (haddr == `OFS_CURRENT_DESC) ? cur_word :
        (haddr == `OFS_HEAD_DESC) ? head_word :
        (haddr == `OFS_OPERATING_CONTROL) ?
            {31'h00000000, enable_q} :
        (haddr == `OFS_COMMAND_STATUS) ?
            {30'h00000000, filled_q, 1'b0} :
        32'h00000000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hrdata <= 32'h00000000;
            hresp <= `HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= `HRESP_OKAY;
            if (accept & ~hwrite) begin
                hrdata <= next_rdata;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            current_ptr <= `RESET_PTR;
            list_end <= 1'b1;
            list_enable <= `RESET_ENABLE;
            list_filled <= `RESET_FILLED;
        end else begin
            current_ptr <= cur_q;
            list_end <= at_end;
            list_enable <= enable_q;
            list_filled <= filled_q;
        end
    end

    // checks

    chk_read_live: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && haddr == `OFS_CURRENT_DESC)
        |=> hrdata == {$past(cur_q), `PTR_RSVD_VALUE}
    ) else $error("current pointer read does not match live value");

    chk_reserved_zero: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && haddr == `OFS_CURRENT_DESC)
        ##1 hreadyout |-> hrdata[3:0] == 4'h0
    ) else $error("reserved pointer bits read nonzero");

    chk_advance_next: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (enable_q && advance.done && !reload)
        |=> cur_q == $past(advance.next_ptr)
    ) else $error("pointer did not advance to next descriptor");

    chk_reload_head: assert property (
        @(posedge hclk) disable iff (!hresetn)
        reload |=> cur_q == $past(head_ptr) ##1 current_ptr == $past(head_ptr, 2)
    ) else $error("end of list did not reload head pointer");

    chk_reload_clears: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (reload && !set_filled) |=> !filled_q ##1 !list_filled
    ) else $error("filled flag not cleared after reload");

    chk_idle_end: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (enable_q && at_end && !filled_q && !advance.done && !wr_ctrl)
        |=> at_end
    ) else $error("pointer left end of list without filled flag");

    chk_frame_resume: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (frame_start && !cur_load_hi && !step) |=> $stable(cur_q)
    ) else $error("frame start moved the pointer");

    chk_write_blocked: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_phase && req.addr == `OFS_CURRENT_DESC && enable_q
            && !reload && !step) |=> $stable(cur_q)
    ) else $error("pointer written while list enabled");

    chk_write_taken: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_cur |=> cur_q == $past(hwdata[31:4])
    ) else $error("pointer write while disabled was lost");

    chk_init_head: assert property (
        @(posedge hclk) disable iff (!hresetn)
        init_load |=> head_ptr == $past(hca_head_ptr)
    ) else $error("head pointer not loaded at init");

    chk_bus_okay: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $past(hresetn) |-> hreadyout && hresp == `HRESP_OKAY
    ) else $error("bus answer not ready and okay");

    chk_reset_zero: assert property (
        @(posedge hclk)
        !hresetn ##1 !hresetn |-> cur_q == 28'h0000000 && list_end
    ) else $error("pointer not zero during reset");

    chk_disabled_hold: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (!enable_q && !wr_cur) |=> $stable(cur_q)
    ) else $error("pointer moved while list disabled");

    chk_flag_set: assert property (
        @(posedge hclk) disable iff (!hresetn)
        set_filled |=> filled_q
    ) else $error("software set of filled flag was lost");

    chk_head_write: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_head && !init_load) |=> head_ptr == $past(hwdata[31:4])
    ) else $error("head pointer write was lost");

    chk_enable_mirror: assert property (
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> list_enable == $past(enable_q)
    ) else $error("list enable output does not follow control");

    chk_end_mirror: assert property (
        @(posedge hclk) disable iff (!hresetn)
        list_end == (current_ptr == 28'h0000000)
    ) else $error("end of list output does not match pointer");

    cov_reload: cover property (
        @(posedge hclk) disable iff (!hresetn) reload
    );

    cov_advance_then_end: cover property (
        @(posedge hclk) disable iff (!hresetn)
        step ##1 at_end && enable_q
    );

    cov_blocked_write: cover property (
        @(posedge hclk) disable iff (!hresetn)
        wr_phase && req.addr == `OFS_CURRENT_DESC && enable_q
    );

    cov_set_beats_clear: cover property (
        @(posedge hclk) disable iff (!hresetn) reload && set_filled
    );

    // hsize unused: only whole-word single transfers reach this block
    wire logic unused_size;
    assign unused_size = ^hsize;

endmodule : control_list_current_pointer

//--- tb/tb.sv
`timescale 1ns/1ps
`include "ctl_list_consts.svh"

module tb;
    // clock and reset
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    // bus master side
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    // walker side
    ctl_list_pkg::advance_t adv = '0;
    logic frame_start = 1'b0;
    logic init_load = 1'b0;
    logic [27:0] hca_head_ptr = 28'h0000000;
    logic [27:0] current_ptr;
    logic list_end;
    logic list_enable;
    logic list_filled;
    int num_errors = 0;
    int compares = 0;

    always #20 hclk = ~hclk;

    // single slave, so its hreadyout is the bus hready
    control_list_current_pointer i_dut (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .advance(adv),
        .frame_start(frame_start),
        .init_load(init_load),
        .hca_head_ptr(hca_head_ptr),
        .current_ptr(current_ptr),
        .list_end(list_end),
        .list_enable(list_enable),
        .list_filled(list_filled)
    );

    task end_sim;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    // sampled values are the ones from before this edge's updates
    task wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                num_errors++;
                $display("unexpected at %0t: bus hang", $time);
                end_sim();
            end
            @(posedge hclk);
        end
    endtask : wait_ready

    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        r = hrdata;
        check({31'h0, hresp}, {31'h0, `HRESP_OKAY});
    endtask : bus

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h00000000, r);
        check(r, exp);
    endtask : rd_chk

    task pulse_adv(input logic [27:0] n);
        adv <= '{done: 1'b1, next_ptr: n};
        @(posedge hclk);
        adv.done <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask : pulse_adv

    task t_reset;
        rd_chk(`OFS_CURRENT_DESC, 32'h00000000);
        check({31'h0, list_end}, 32'h00000001);
        check({31'h0, list_filled}, 32'h00000000);
        rd_chk(8'h10, 32'h00000000);
        $display("test reset done");
    endtask : t_reset

    task t_write;
        wr(`OFS_CURRENT_DESC, 32'h1234567f);
        rd_chk(`OFS_CURRENT_DESC, 32'h12345670);
        check({4'h0, current_ptr}, 32'h01234567);
        // a served report while disabled must not move the pointer
        pulse_adv(28'h0000abc);
        check({4'h0, current_ptr}, 32'h01234567);
        $display("test write done");
    endtask : t_write

    task t_walk;
        wr(`OFS_OPERATING_CONTROL, 32'h00000001);
        // the enable copy shows one edge after the control bit
        repeat (2) @(posedge hclk);
        check({31'h0, list_enable}, 32'h00000001);
        // back-to-back served descriptors
        adv <= '{done: 1'b1, next_ptr: 28'h00a0b0c};
        @(posedge hclk);
        adv <= '{done: 1'b1, next_ptr: 28'h00a0b1c};
        @(posedge hclk);
        adv.done <= 1'b0;
        repeat (3) @(posedge hclk);
        check({4'h0, current_ptr}, 32'h000a0b1c);
        rd_chk(`OFS_CURRENT_DESC, 32'h00a0b1c0);
        frame_start <= 1'b1;
        @(posedge hclk);
        frame_start <= 1'b0;
        repeat (2) @(posedge hclk);
        rd_chk(`OFS_CURRENT_DESC, 32'h00a0b1c0);
        // write while enabled must be dropped
        wr(`OFS_CURRENT_DESC, 32'hdead0000);
        rd_chk(`OFS_CURRENT_DESC, 32'h00a0b1c0);
        $display("test walk done");
    endtask : t_walk

    task t_reload;
        init_load <= 1'b1;
        hca_head_ptr <= 28'h0c0ffee;
        @(posedge hclk);
        init_load <= 1'b0;
        rd_chk(`OFS_HEAD_DESC, 32'hc0ffee0);
        wr(`OFS_COMMAND_STATUS, 32'h00000002);
        repeat (2) @(posedge hclk);
        // pointer not zero yet, so the flag must stay
        check({31'h0, list_filled}, 32'h00000001);
        pulse_adv(28'h0000000);
        rd_chk(`OFS_CURRENT_DESC, 32'hc0ffee0);
        check({31'h0, list_filled}, 32'h00000000);
        pulse_adv(28'h0000000);
        rd_chk(`OFS_CURRENT_DESC, 32'h00000000);
        check({31'h0, list_end}, 32'h00000001);
        // flag set while already at the end reloads at once
        wr(`OFS_COMMAND_STATUS, 32'h00000002);
        repeat (2) @(posedge hclk);
        rd_chk(`OFS_CURRENT_DESC, 32'hc0ffee0);
        check({31'h0, list_filled}, 32'h00000000);
        $display("test reload done");
    endtask : t_reload

    task t_reset_mid;
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        check({31'h0, hreadyout}, 32'h00000000);
        check({4'h0, current_ptr}, 32'h00000000);
        check({31'h0, list_end}, 32'h00000001);
        check({31'h0, list_enable}, 32'h00000000);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rd_chk(`OFS_CURRENT_DESC, 32'h00000000);
        rd_chk(`OFS_OPERATING_CONTROL, 32'h00000000);
        $display("test mid reset done");
    endtask : t_reset_mid

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        t_reset();
        t_write();
        t_walk();
        t_reload();
        t_reset_mid();
        end_sim();
    end
endmodule : tb
